// file: src/vic_ctrl.sv
// Function
// RQ1: Priority register orders pending request selection
// RQ2: Grant disables interrupts, saves PC and flags
// RQ3: Branch through 16-bit vector at source location
// RQ4: Flags keep setting while masked, for polling
// RQ5: Comparator one feeds line two, two line zero
// RQ6: Request bits 7:6 choose lines two/zero edges
// RQ7: Software can read pin states of lines
// RQ8: Priority write-only; request and mask read/write
// RQ9: Mask global enable changes only via instructions
// RQ10: Either configured edge wakes from stop mode
// RQ11: Six sources: three pins, two timers, detector
// RQ12: Vector pairs at bytes 0,1 through 10,11
// RQ13: Port3 mode bit selects line one source
// RQ14: Flags latch on edge, clear on grant/write
// RQ15: Request needs individual and global enable
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module vic_ctrl (
    input wire logic ref_clk, // 125 MHz core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [vic_pkg::VIC_ADDR_W-1:0] address, // Byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic port3_line1, // Pin, line two source
    input wire logic port3_line2, // Pin, line zero source
    input wire logic port3_line3, // Pin, line one source
    input wire logic analog_cmp_in_one, // Comparator one output
    input wire logic analog_cmp_in_two, // Comparator two output
    input wire logic stop_recovery_src, // Stop recovery logic output
    input wire logic t16_timeout, // 16-bit timer event pulse
    input wire logic t8_timeout, // 8-bit timer event pulse
    input wire logic low_voltage_detector, // Detector event pulse
    input wire logic core_accept, // Core at instruction boundary
    input wire logic enable_int_instr, // Enable-interrupt instr pulse
    input wire logic disable_int_instr, // Disable-interrupt instr pulse
    input wire logic [7:0] pm_rdata, // Program byte, 1 cycle after rd
    output vic_pkg::vic_pm_t pm_o, // Program memory fetch
    output vic_pkg::vic_core_t core_o, // Core handshake
    output logic stop_wake // Stop-mode recovery pulse
);
    import vic_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Rotating priority: start line from priority register, wraps
    function automatic logic [2:0] vic_pick(input logic [5:0] pend,
                                            input logic [2:0] start);
        logic [2:0] idx;
        logic [2:0] pick;
        logic found;
        idx = (start < 3'd6) ? start : 3'd0;
        pick = 3'd0;
        found = 1'b0;
        for (int k = 0; k < VIC_NUM_LINES; k++) begin
            if (!found && pend[idx]) begin
                pick = idx;
                found = 1'b1;
            end
            idx = (idx == 3'd5) ? 3'd0 : idx + 3'd1;
        end
        return pick;
    endfunction : vic_pick

    function automatic logic [15:0] vic_vec_addr(input logic [2:0] line);
        return VIC_VEC_BASE + {12'h000, line, 1'b0}; // RQ12
    endfunction : vic_vec_addr

    function automatic logic vic_hit(input logic [VIC_ADDR_W-1:0] a,
                                     input logic [7:0] idx);
        return a[VIC_ADDR_W-1:2] == idx;
    endfunction : vic_hit

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [5:0] pin_meta_r, pin_meta_nxt;
    logic [5:0] pin_sync_r, pin_sync_nxt;
    logic [5:0] pin_prev_r, pin_prev_nxt;
    logic [2:0] arm_r, arm_nxt;
    logic [5:0] rise, fall;

    always_comb begin
        pin_meta_nxt = {stop_recovery_src, analog_cmp_in_two,
                        analog_cmp_in_one, port3_line3, port3_line2,
                        port3_line1};
        pin_sync_nxt = pin_meta_r;
        pin_prev_nxt = pin_sync_r;
        arm_nxt = {arm_r[1:0], 1'b1};
        // Sync and history reset low; a pin that idles high would
        // otherwise show a false rise until three real samples are in
        rise = arm_r[2] ? (pin_sync_r & ~pin_prev_r) : 6'h00;
        fall = arm_r[2] ? (~pin_sync_r & pin_prev_r) : 6'h00;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= 6'h00;
            pin_sync_r <= 6'h00;
            pin_prev_r <= 6'h00;
            arm_r <= 3'h0;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
            pin_prev_r <= pin_prev_nxt;
            arm_r <= arm_nxt;
        end
    end

    // ------------------------------------------------------------
    // Registers, request logic and bus slave
    // ------------------------------------------------------------
    logic [7:0] prio_r, prio_nxt;
    logic [5:0] flags_r, flags_nxt;
    logic [1:0] edge_sel_r, edge_sel_nxt;
    logic [5:0] mask_r, mask_nxt;
    logic global_r, global_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wake_r, wake_nxt;
    logic analog;
    logic r2, f2, r0, f0;
    logic ev0, ev1, ev2;
    logic [5:0] events, enabled;
    logic wr_go, wr_lane0;
    logic grant;
    logic [2:0] grant_idx;

    always_comb begin
        analog = ctrl_r[VIC_CTRL_ANALOG_BIT];
        // Analog mode routes comparators onto lines two and zero
        r2 = analog ? rise[VIC_PIN_AN1] : rise[VIC_PIN_L1]; // RQ5
        f2 = analog ? fall[VIC_PIN_AN1] : fall[VIC_PIN_L1]; // RQ5
        r0 = analog ? rise[VIC_PIN_AN2] : rise[VIC_PIN_L2]; // RQ5
        f0 = analog ? fall[VIC_PIN_AN2] : fall[VIC_PIN_L2]; // RQ5
        if (edge_sel_r == 2'b11) begin // RQ6
            ev2 = r2 | f2;
            ev0 = r0 | f0;
        end else begin
            ev2 = edge_sel_r[1] ? r2 : f2; // RQ6
            ev0 = edge_sel_r[0] ? r0 : f0; // RQ6
        end
        ev1 = analog ? fall[VIC_PIN_SMR] : fall[VIC_PIN_L3]; // RQ13
        events = {low_voltage_detector, t8_timeout, t16_timeout,
                  ev2, ev1, ev0}; // RQ11
        enabled = flags_r & mask_r & {6{global_r}}; // RQ15
        grant_idx = vic_pick(enabled, prio_r[2:0]); // RQ1

        // A write acts only at the edge that shows wait low, so a
        // request held through its wait cycle lands exactly once
        wr_go = write && !wait_r;
        wr_lane0 = wr_go && byteenable[0];
        prio_nxt = prio_r;
        flags_nxt = flags_r;
        edge_sel_nxt = edge_sel_r;
        mask_nxt = mask_r;
        global_nxt = global_r;
        ctrl_nxt = ctrl_r;
        if (wr_lane0 && vic_hit(address, VIC_IDX_PRIO))
            prio_nxt = writedata[7:0]; // RQ8
        if (wr_lane0 && vic_hit(address, VIC_IDX_REQ)) begin
            flags_nxt = writedata[5:0]; // RQ14
            edge_sel_nxt = writedata[VIC_REQ_EDGE2_BIT:VIC_REQ_EDGE0_BIT];
        end
        // Global enable ignores bus writes
        if (wr_lane0 && vic_hit(address, VIC_IDX_MASK))
            mask_nxt = writedata[5:0]; // RQ9
        if (wr_lane0 && vic_hit(address, VIC_IDX_CTRL))
            ctrl_nxt = writedata[1:0];
        if (enable_int_instr)
            global_nxt = 1'b1; // RQ9
        if (disable_int_instr)
            global_nxt = 1'b0; // RQ9
        if (grant) begin
            global_nxt = 1'b0; // RQ2
            flags_nxt[grant_idx] = 1'b0; // RQ14
        end
        // New events win over any clear; mask does not gate them
        flags_nxt = flags_nxt | events; // RQ4

        // Wake needs no mask: stop recovery runs with interrupts off
        wake_nxt = ctrl_r[VIC_CTRL_STOP_EN_BIT] & (ev0 | ev2); // RQ10

        // One wait cycle: request seen, then answer with wait low
        wait_nxt = !((read || write) && wait_r);
        rdata_nxt = rdata_r;
        // Unmapped indices and the write-only priority register read 0
        if (read && wait_r) begin
            rdata_nxt = 32'h0000_0000;
            if (vic_hit(address, VIC_IDX_REQ))
                rdata_nxt[7:0] = {edge_sel_r, flags_r}; // RQ8
            else if (vic_hit(address, VIC_IDX_MASK))
                rdata_nxt[7:0] = {global_r, 1'b0, mask_r}; // RQ8
            else if (vic_hit(address, VIC_IDX_PINS))
                rdata_nxt[7:0] = {2'b00, pin_sync_r}; // RQ7
            else if (vic_hit(address, VIC_IDX_CTRL))
                rdata_nxt[7:0] = {6'h00, ctrl_r};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_r <= VIC_PRIO_RST;
            flags_r <= VIC_FLAGS_RST;
            edge_sel_r <= VIC_EDGE_RST;
            mask_r <= VIC_MASK_RST;
            global_r <= VIC_GLOBAL_RST;
            ctrl_r <= VIC_CTRL_RST;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            wake_r <= 1'b0;
        end else begin
            prio_r <= prio_nxt;
            flags_r <= flags_nxt;
            edge_sel_r <= edge_sel_nxt;
            mask_r <= mask_nxt;
            global_r <= global_nxt;
            ctrl_r <= ctrl_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt machine cycle
    // ------------------------------------------------------------
    vic_state_t state_r, state_nxt;
    vic_core_t core_r, core_nxt;
    vic_pm_t pm_r, pm_nxt;
    logic [7:0] vec_hi_r, vec_hi_nxt;

    // Grant only between machine cycles, so one vector is in flight
    assign grant = (state_r == VIC_ST_IDLE) && core_accept && (|enabled);

    always_comb begin
        state_nxt = state_r;
        vec_hi_nxt = vec_hi_r;
        core_nxt = core_r;
        pm_nxt = pm_r;
        core_nxt.save_ctx = 1'b0;
        core_nxt.isr_valid = 1'b0;
        // Request hint only: the grant re-checks the enabled flags, so
        // a one-cycle-late int_req can never cause a stale grant
        core_nxt.int_req = (state_nxt == VIC_ST_IDLE) && !grant
                           && (|enabled);
        unique case (state_r)
            VIC_ST_IDLE: begin
                if (grant) begin
                    core_nxt.save_ctx = 1'b1; // RQ2
                    pm_nxt.rd = 1'b1;
                    pm_nxt.addr = vic_vec_addr(grant_idx); // RQ3
                    state_nxt = VIC_ST_ADDR1;
                end
            end
            VIC_ST_ADDR1: begin
                pm_nxt.addr = pm_r.addr + 16'h0001; // RQ3
                state_nxt = VIC_ST_BYTE0;
            end
            VIC_ST_BYTE0: begin
                // Memory answers a cycle after the address: high byte now
                vec_hi_nxt = pm_rdata; // RQ3
                pm_nxt.rd = 1'b0;
                state_nxt = VIC_ST_BYTE1;
            end
            VIC_ST_BYTE1: begin
                core_nxt.isr_valid = 1'b1;
                core_nxt.isr_addr = {vec_hi_r, pm_rdata}; // RQ3
                state_nxt = VIC_ST_IDLE;
            end
        endcase
        if (state_nxt != VIC_ST_IDLE)
            core_nxt.int_req = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= VIC_ST_IDLE;
            core_r <= '0;
            pm_r <= '0;
            vec_hi_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            core_r <= core_nxt;
            pm_r <= pm_nxt;
            vec_hi_r <= vec_hi_nxt;
        end
    end

    assign readdata = rdata_r;
    assign waitrequest = wait_r;
    assign pm_o = pm_r;
    assign core_o = core_r;
    assign stop_wake = wake_r;
endmodule : vic_ctrl

`default_nettype wire

// file: src/vic_pkg.sv
package vic_pkg;
    // ------------------------------------------------------------
    // Register map: printed offsets are indices, byte address = 4x
    // ------------------------------------------------------------
    localparam logic [7:0] VIC_IDX_PRIO = 8'hf9;
    localparam logic [7:0] VIC_IDX_REQ = 8'hfa;
    localparam logic [7:0] VIC_IDX_MASK = 8'hfb;
    localparam logic [7:0] VIC_IDX_PINS = 8'hfc;
    localparam logic [7:0] VIC_IDX_CTRL = 8'hfd;
    localparam int VIC_ADDR_W = 10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int VIC_NUM_LINES = 6;
    localparam int VIC_REQ_EDGE2_BIT = 7;
    localparam int VIC_REQ_EDGE0_BIT = 6;
    localparam int VIC_MASK_GLOBAL_BIT = 7;
    localparam int VIC_CTRL_STOP_EN_BIT = 0;
    localparam int VIC_CTRL_ANALOG_BIT = 1;
    localparam logic [7:0] VIC_PRIO_RST = 8'h00;
    localparam logic [5:0] VIC_FLAGS_RST = 6'h00;
    localparam logic [1:0] VIC_EDGE_RST = 2'h0;
    localparam logic [5:0] VIC_MASK_RST = 6'h00;
    localparam logic VIC_GLOBAL_RST = 1'b0;
    localparam logic [1:0] VIC_CTRL_RST = 2'h0;

    // Vector pairs: line n at program bytes 2n (high) and 2n+1 (low)
    localparam logic [15:0] VIC_VEC_BASE = 16'h0000;

    // Synchronised pin indices
    localparam int VIC_PIN_L1 = 0;
    localparam int VIC_PIN_L2 = 1;
    localparam int VIC_PIN_L3 = 2;
    localparam int VIC_PIN_AN1 = 3;
    localparam int VIC_PIN_AN2 = 4;
    localparam int VIC_PIN_SMR = 5;

    typedef enum logic [1:0] {
        VIC_ST_IDLE = 2'b00,
        VIC_ST_ADDR1 = 2'b01,
        VIC_ST_BYTE0 = 2'b10,
        VIC_ST_BYTE1 = 2'b11
    } vic_state_t;

    typedef struct packed {
        logic int_req;
        logic save_ctx;
        logic isr_valid;
        logic [15:0] isr_addr;
    } vic_core_t;

    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } vic_pm_t;
endpackage : vic_pkg

// file: tb/vic_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks of the interrupt controller
// ------------------------------------------------------------
module vic_ctrl_asserts (
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [vic_pkg::VIC_ADDR_W-1:0] address, // Byte address
    input wire logic read, // Bus read
    input wire logic write, // Bus write
    input wire logic [31:0] readdata, // Bus read data
    input wire logic waitrequest, // Bus wait
    input wire logic core_accept, // Core at boundary
    input wire logic [7:0] pm_rdata, // Program byte
    input wire vic_pkg::vic_pm_t pm_o, // Vector fetch
    input wire vic_pkg::vic_core_t core_o // Core handshake
);
    import vic_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_wait_once: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("bus answer late");
    a_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("wait low too long");
    a_prio_wo: assert property (read && waitrequest
        && address[9:2] == VIC_IDX_PRIO |=> readdata == 32'h0)
        else $error("priority register readable");
    a_grant_acc: assert property (core_o.save_ctx
        |-> $past(core_accept)) else $error("grant without accept");
    a_global_off: assert property (core_o.save_ctx
        |=> !core_o.save_ctx [*8]) else $error("grant while disabled");
    a_vec_slot: assert property (core_o.save_ctx |-> pm_o.rd
        && pm_o.addr[0] == 1'b0 && pm_o.addr < 16'h000c)
        else $error("vector slot wrong");
    a_vec_pair: assert property (core_o.save_ctx |=> pm_o.rd
        && pm_o.addr == $past(pm_o.addr) + 16'h0001)
        else $error("second vector byte wrong");
    a_isr_time: assert property (core_o.save_ctx
        |-> ##3 core_o.isr_valid) else $error("vector late");
    a_isr_data: assert property (core_o.isr_valid
        |-> core_o.isr_addr == {$past(pm_rdata, 2), $past(pm_rdata)})
        else $error("vector value wrong");
endmodule : vic_ctrl_asserts
`default_nettype wire

// file: tb/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Program memory holding the vector table
// ------------------------------------------------------------
module vic_core_model (
    input wire logic ref_clk, // Core clock
    input wire vic_pkg::vic_pm_t pm_o, // Fetch request
    output logic [7:0] pm_rdata // Byte one cycle after request
);
    import vic_pkg::*;
    logic [7:0] byte_nxt;
    // Every byte differs, so a wrong slot or order shows up
    assign byte_nxt = (pm_o.addr[7:0] * 8'h11) ^ 8'h5a;
    initial pm_rdata = 8'h00;
    // Idle cycles invert the bus so a stale byte never passes
    always @(posedge ref_clk) begin
        if (pm_o.rd) begin
            pm_rdata <= byte_nxt;
        end else begin
            pm_rdata <= ~pm_rdata;
        end
    end
endmodule : vic_core_model
`default_nettype wire

// file: tb/vic_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl_test;
    import vic_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [VIC_ADDR_W-1:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, stop_wake, core_accept = 1'b0;
    logic [5:0] pins = 6'h00;
    logic [2:0] tmr = 3'h0;
    logic ei = 1'b0;
    logic di = 1'b0;
    logic [7:0] pm_rdata;
    logic [15:0] isr_seen;
    logic [31:0] rnd = 32'h00014256;
    vic_pm_t pm_o;
    vic_core_t core_o;
    int bad_count = 0, check_count = 0, save_cnt = 0, isr_cnt = 0;
    int wake_cnt = 0;
    always #4 ref_clk = ~ref_clk;
    vic_ctrl dut (.ref_clk, .rst_n, .address, .read, .write, .writedata,
        .byteenable(4'h1), .readdata, .waitrequest, .port3_line1(pins[0]),
        .port3_line2(pins[1]), .port3_line3(pins[2]),
        .analog_cmp_in_one(pins[3]), .analog_cmp_in_two(pins[4]),
        .stop_recovery_src(pins[5]), .t16_timeout(tmr[0]),
        .t8_timeout(tmr[1]), .low_voltage_detector(tmr[2]), .core_accept,
        .enable_int_instr(ei), .disable_int_instr(di), .pm_rdata, .pm_o,
        .core_o, .stop_wake);
    vic_core_model u_mem (.ref_clk, .pm_o, .pm_rdata);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [7:0] vb(input int a);
        return (a[7:0] * 8'h11) ^ 8'h5a;
    endfunction : vb
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input bit wr, input logic [7:0] idx,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        // Wait low is sampled at the rising edge, where the write lands
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (waitrequest !== 1'b0) begin
            bad_count++;
            summarize();
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask : rdchk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic pulse(input bit en);
        if (en) ei <= 1'b1;
        else di <= 1'b1;
        @(posedge ref_clk);
        if (en) ei <= 1'b0;
        else di <= 1'b0;
    endtask : pulse
    // Pulses stand one cycle, so the falling edge sees each once
    always @(negedge ref_clk) begin
        if (core_o.save_ctx === 1'b1) save_cnt++;
        if (core_o.isr_valid === 1'b1) begin
            isr_cnt++;
            isr_seen = core_o.isr_addr;
        end
        if (stop_wake === 1'b1) wake_cnt++;
    end
    initial begin
        #800000;
        bad_count++;
        summarize();
    end
    initial begin
        int es, n, k, p, ln, wk;
        logic [5:0] f;
        logic [1:0] s;
        cyc(20);
        rst_n <= 1'b1;
        cyc(2);
        rdchk(VIC_IDX_REQ, 8'h00);
        rdchk(VIC_IDX_MASK, 8'h00);
        rdchk(8'h00, 8'h00);
        wr(VIC_IDX_PRIO, 8'h05);
        rdchk(VIC_IDX_PRIO, 8'h00);
        wr(VIC_IDX_MASK, 8'hbf);
        rdchk(VIC_IDX_MASK, 8'h3f);
        tmr <= 3'h7;
        cyc(1);
        tmr <= 3'h0;
        cyc(2);
        rdchk(VIC_IDX_REQ, 8'h38);
        chk({15'h0, core_o.int_req}, 16'h0);
        wr(VIC_IDX_CTRL, 8'h01);
        wk = 0;
        for (es = 0; es < 4; es++) begin
            s = es[1:0];
            wr(VIC_IDX_REQ, {s, 6'h00});
            pins <= 6'h07;
            cyc(6);
            rdchk(VIC_IDX_PINS, 8'h07);
            rdchk(VIC_IDX_REQ, {s, 3'h0, s[1], 1'b0, s[0]});
            wk += (s != 2'h0);
            wr(VIC_IDX_REQ, {s, 6'h00});
            pins <= 6'h00;
            cyc(6);
            rdchk(VIC_IDX_REQ, {s, 3'h0, ~s[1] | &s, 1'b1,
                ~s[0] | &s});
            wk++;
            chk(16'(wake_cnt), 16'(wk));
        end
        // Analog mode: comparators and stop source, port pins ignored
        wr(VIC_IDX_CTRL, 8'h03);
        wr(VIC_IDX_REQ, 8'hc0);
        pins <= 6'h0f;
        cyc(6);
        rdchk(VIC_IDX_REQ, 8'hc4);
        wr(VIC_IDX_REQ, 8'hc0);
        pins <= 6'h30;
        cyc(6);
        rdchk(VIC_IDX_PINS, 8'h30);
        rdchk(VIC_IDX_REQ, 8'hc5);
        wr(VIC_IDX_REQ, 8'hc0);
        pins <= 6'h10;
        cyc(6);
        rdchk(VIC_IDX_REQ, 8'hc2);
        chk(16'(wake_cnt), 16'(wk + 2));
        for (n = 0; n < 6; n++) begin
            rnd = lfsr(rnd);
            p = rnd[2:0];
            f = rnd[8:3];
            if (f == 6'h00) f = 6'h21;
            wr(VIC_IDX_PRIO, {5'h00, rnd[2:0]});
            wr(VIC_IDX_REQ, {2'h0, f});
            pulse(1'b1);
            cyc(2);
            chk({15'h0, core_o.int_req}, 16'h0001);
            pulse(1'b0);
            core_accept <= 1'b1;
            cyc(4);
            chk(16'(save_cnt), 16'(n));
            pulse(1'b1);
            k = 0;
            while (isr_cnt == n && k < 20) begin
                @(posedge ref_clk);
                k++;
            end
            if (isr_cnt == n) begin
                bad_count++;
                summarize();
            end
            ln = -1;
            for (k = 0; k < 6; k++) begin
                if (ln < 0 && f[((p > 5 ? 0 : p) + k) % 6])
                    ln = ((p > 5 ? 0 : p) + k) % 6;
            end
            chk(isr_seen, {vb(2 * ln), vb(2 * ln + 1)});
            core_accept <= 1'b0;
            f[ln] = 1'b0;
            rdchk(VIC_IDX_REQ, {2'h0, f});
            rdchk(VIC_IDX_MASK, 8'h3f);
        end
        // Mid-run reset with pins high: no state survives, no false edge
        rst_n <= 1'b0;
        pins <= 6'h3f;
        cyc(4);
        rst_n <= 1'b1;
        cyc(8);
        rdchk(VIC_IDX_REQ, 8'h00);
        rdchk(VIC_IDX_MASK, 8'h00);
        rdchk(VIC_IDX_PINS, 8'h3f);
        summarize();
    end
endmodule : vic_ctrl_test
bind vic_ctrl vic_ctrl_asserts u_chk (.ref_clk, .rst_n, .address, .read,
    .write, .readdata, .waitrequest, .core_accept, .pm_rdata, .pm_o,
    .core_o);
`default_nettype wire
